/* rtl/asp_pkg.sv */
// constants shared by the serial port and its result buffer
// assumes a single 20 MHz core clock; all pins arrive asynchronously
package asp_pkg;

   // word geometry
   localparam int WORD_W     = 24;
   localparam int CNT_W      = 5;
   localparam int FIFO_DEPTH = 8;

   // control word fields
   localparam int MODE_HI      = 23;
   localparam int MODE_LO      = 21;
   localparam int UNIPOLAR_BIT = 12;
   localparam logic [2:0]  MODE_NORMAL = 3'h0;
   localparam logic [23:0] CTRL_RESET  = 24'h00_0000;

   // bit counts inside a frame
   localparam logic [4:0] LAST_BIT  = 5'h17;
   localparam logic [4:0] FULL_WORD = 5'h18;

   // self-clock: core cycles per half period of the driven serial clock
   localparam int SCLK_HALF_CYC = 4;

   // synchroniser order: 0 write strobe, 1 read strobe, 2 select,
   // 3 serial clock in, 4 serial data in, 5 self-clock strap
   localparam int SYNC_W = 6;
   // strobes and the serial clock idle high, so no false edge after reset
   localparam logic [5:0] SYNC_RST = 6'h0B;

   typedef enum logic [3:0] {
      ASP_IDLE  = 4'b0001,
      ASP_WRITE = 4'b0010,
      ASP_READ  = 4'b0100,
      ASP_DONE  = 4'b1000
   } asp_state_t;

endpackage : asp_pkg

/* rtl/asp_fifo.sv */
// result buffer between the converter and the serial port
// assumes both sides run on clk_i; output data comes from storage flops
`timescale 1ns/1ns
module asp_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // fill side
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   // drain side
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   logic             push;
   logic             pop;

   assign in_ready_o  = (fill != (AW+1)'(DEPTH));
   assign out_valid_o = (fill != '0);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_ready_i & out_valid_o;
   assign out_data_o  = mem[rd_ptr];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers wrap explicitly so non power-of-two depths still work
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : asp_fifo

/* rtl/asp_serial_port.sv */
// framed serial port of a measurement converter with its control word
// assumes all pins are asynchronous to clk_i and the link clock is slow
// against it; results arrive as two's complement words with valid/ready
`timescale 1ns/1ns
module asp_serial_port #(
   parameter int WORD_W     = asp_pkg::WORD_W,
   parameter int FIFO_DEPTH = asp_pkg::FIFO_DEPTH,
   parameter int SCLK_HALF  = asp_pkg::SCLK_HALF_CYC
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // frame pins
   input  wire logic              write_frame_strobe_n_i,
   input  wire logic              read_frame_strobe_n_i,
   input  wire logic              register_select_i,
   input  wire logic              self_clock_i,
   // serial clock pin
   input  wire logic              sclk_i,
   output logic                   sclk_o,
   output logic                   sclk_oe_o,
   // serial data pin
   input  wire logic              serial_io_line_i,
   output logic                   serial_io_line_o,
   output logic                   serial_io_line_oe_o,
   // ready pin
   output logic                   result_ready_n_o,
   // converter side
   input  wire logic [WORD_W-1:0] sample_i,
   input  wire logic              sample_valid_i,
   output logic                   sample_ready_o,
   input  wire logic              cal_done_i,
   // live control word
   output logic      [WORD_W-1:0] control_config_word_o
);
   localparam int DW = $clog2(SCLK_HALF + 1);

   // synchronised pins
   logic [asp_pkg::SYNC_W-1:0] s1;
   logic [asp_pkg::SYNC_W-1:0] s2;
   logic [asp_pkg::SYNC_W-1:0] s3;
   logic [asp_pkg::SYNC_W-1:0] pin;
   logic [asp_pkg::SYNC_W-1:0] next_pin;
   logic [asp_pkg::SYNC_W-1:0] pin_rise;
   logic [asp_pkg::SYNC_W-1:0] pin_fall;

   // frame control
   asp_pkg::asp_state_t state;
   logic [4:0]          bit_cnt;
   logic [WORD_W-1:0]   hold;
   logic [WORD_W-1:0]   shifter;
   logic                sel_result;
   logic                drive_en;
   logic                done_hold;
   logic                cal_flag;
   logic                word_done;
   logic                self_mode;

   // serial clock
   logic [DW-1:0] div_cnt;
   logic          sclk_int;
   logic          tick;
   logic          clk_run;
   logic          rise;
   logic          fall;

   // result buffer
   logic [WORD_W-1:0] out_data;
   logic              out_valid;
   logic              pop;
   logic [WORD_W-1:0] coded;

   // three stages; a level counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < asp_pkg::SYNC_W; g++) begin : g_sync
         logic raw;
         if (g == 0) begin : g_tfs
            assign raw = write_frame_strobe_n_i;
         end else if (g == 1) begin : g_rfs
            assign raw = read_frame_strobe_n_i;
         end else if (g == 2) begin : g_sel
            assign raw = register_select_i;
         end else if (g == 3) begin : g_sck
            assign raw = sclk_i;
         end else if (g == 4) begin : g_sdi
            assign raw = serial_io_line_i;
         end else begin : g_mode
            assign raw = self_clock_i;
         end
         always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
               s1[g]  <= asp_pkg::SYNC_RST[g];
               s2[g]  <= asp_pkg::SYNC_RST[g];
               s3[g]  <= asp_pkg::SYNC_RST[g];
               pin[g] <= asp_pkg::SYNC_RST[g];
            end else begin
               s1[g]  <= raw;
               s2[g]  <= s1[g];
               s3[g]  <= s2[g];
               pin[g] <= next_pin[g];
            end
         end
         assign next_pin[g] = (s2[g] == s3[g]) ? s2[g] : pin[g];
         assign pin_rise[g] = next_pin[g] & ~pin[g];
         assign pin_fall[g] = ~next_pin[g] & pin[g];
      end
   endgenerate

   assign self_mode = pin[5];

   // result buffer; back-pressure reaches the converter via sample_ready_o
   asp_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_data_i   (sample_i),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (sample_ready_o),
      .out_data_o  (out_data),
      .out_valid_o (out_valid),
      .out_ready_i (pop)
   );

   // offset binary is two's complement with the sign bit turned over
   assign coded = {out_data[WORD_W-1] ^
                   ~control_config_word_o[asp_pkg::UNIPOLAR_BIT],
                   out_data[WORD_W-2:0]};

   // self-clock generator runs only inside a frame and stops at 24 bits
   assign clk_run = self_mode &
                    (state == asp_pkg::ASP_WRITE ||
                     state == asp_pkg::ASP_READ) &
                    (bit_cnt != asp_pkg::FULL_WORD);
   assign tick    = clk_run && (div_cnt == DW'(SCLK_HALF - 1));

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt  <= '0;
         sclk_int <= 1'b1;
      end else if (!clk_run) begin
         div_cnt  <= '0;
         sclk_int <= 1'b1;
      end else if (tick) begin
         div_cnt  <= '0;
         sclk_int <= ~sclk_int;
      end else begin
         div_cnt  <= div_cnt + 1'b1;
      end
   end

   // driver enable only while a frame is open in self-clock mode
   assign sclk_o    = sclk_int;
   // clock parks high after the word, so the last rise is not lost
   assign sclk_oe_o = self_mode &
                      (state == asp_pkg::ASP_WRITE ||
                       state == asp_pkg::ASP_READ ||
                       state == asp_pkg::ASP_DONE);
   assign rise = self_mode ? (tick & ~sclk_int) : pin_rise[3];
   assign fall = self_mode ? (tick & sclk_int) : pin_fall[3];

   assign word_done = (state == asp_pkg::ASP_READ) && rise &&
                      (bit_cnt == asp_pkg::LAST_BIT);
   assign pop       = word_done & sel_result & out_valid;

   // frame sequencing
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state      <= asp_pkg::ASP_IDLE;
         bit_cnt    <= '0;
         sel_result <= 1'b0;
         drive_en   <= 1'b0;
      end else begin
         case (state)
            asp_pkg::ASP_IDLE: begin
               bit_cnt <= '0;
               if (pin_fall[0]) begin
                  state      <= asp_pkg::ASP_WRITE;
                  sel_result <= pin[2];
               end else if (pin_fall[1]) begin
                  state      <= asp_pkg::ASP_READ;
                  sel_result <= pin[2];
                  // result data only goes out while ready is asserted
                  drive_en   <= ~pin[2] | ~result_ready_n_o;
               end
            end
            asp_pkg::ASP_WRITE: begin
               if (next_pin[0]) begin
                  state <= asp_pkg::ASP_IDLE;
               end else if (rise && bit_cnt != asp_pkg::FULL_WORD) begin
                  bit_cnt <= bit_cnt + 1'b1;
               end
            end
            asp_pkg::ASP_READ: begin
               if (next_pin[1]) begin
                  state    <= asp_pkg::ASP_IDLE;
                  drive_en <= 1'b0;
               end else if (word_done) begin
                  state    <= asp_pkg::ASP_DONE;
                  bit_cnt  <= asp_pkg::FULL_WORD;
                  drive_en <= 1'b0;
               end else if (rise) begin
                  bit_cnt <= bit_cnt + 1'b1;
               end
            end
            asp_pkg::ASP_DONE: begin
               // extra pulses after the word are ignored here
               if (next_pin[1]) begin
                  state <= asp_pkg::ASP_IDLE;
               end
            end
            default: begin
               state    <= asp_pkg::ASP_IDLE;
               drive_en <= 1'b0;
            end
         endcase
      end
   end

   // incoming bits go to a holding register; only the 24th bit also goes straight into the word
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hold <= '0;
      end else if (state == asp_pkg::ASP_WRITE && rise &&
                   bit_cnt != asp_pkg::FULL_WORD) begin
         hold <= {hold[WORD_W-2:0], pin[4]};
      end
   end

   // live word copies only on the 24th bit, so a short frame leaves it
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         control_config_word_o <= asp_pkg::CTRL_RESET;
      end else if (state == asp_pkg::ASP_WRITE && rise && !sel_result &&
                   bit_cnt == asp_pkg::LAST_BIT) begin
         control_config_word_o <= {hold[WORD_W-2:0], pin[4]};
      end
   end

   // outgoing word: loaded at frame start, advanced on falling edges
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shifter <= '0;
      end else if (state == asp_pkg::ASP_IDLE && pin_fall[1] &&
                   !pin_fall[0]) begin
         shifter <= pin[2] ? coded : control_config_word_o;
      end else if (state == asp_pkg::ASP_READ && fall &&
                   bit_cnt != '0) begin
         shifter <= {shifter[WORD_W-2:0], 1'b0};
      end
   end

   assign serial_io_line_o    = shifter[WORD_W-1];
   assign serial_io_line_oe_o = drive_en & (state == asp_pkg::ASP_READ) &
                                ~pin[1];

   // calibration completion is held until a result read finishes;
   // a new completion in the clearing cycle wins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cal_flag <= 1'b0;
      end else if (cal_done_i) begin
         cal_flag <= 1'b1;
      end else if (word_done && sel_result) begin
         cal_flag <= 1'b0;
      end
   end

   // ready pin stays high from a finished word until the frame closes,
   // so the next buffered word gives a fresh falling edge
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         done_hold <= 1'b0;
      end else if (word_done && sel_result) begin
         done_hold <= 1'b1;
      end else if (state == asp_pkg::ASP_IDLE) begin
         done_hold <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         result_ready_n_o <= 1'b1;
      end else begin
         result_ready_n_o <= ~((out_valid | cal_flag) & ~done_hold &
                               ~(word_done & sel_result));
      end
   end

   property p_sclk_in_frame;
      @(posedge clk_i) disable iff (rst_i)
      sclk_oe_o |-> (!pin[0] || !pin[1] || $past(!pin[0] || !pin[1]));
   endproperty
   a_sclk_in_frame: assert property (p_sclk_in_frame)
      else $error("serial clock driven outside a frame");

   property p_data_oe_rfs;
      @(posedge clk_i) disable iff (rst_i)
      serial_io_line_oe_o |-> !pin[1] && state == asp_pkg::ASP_READ;
   endproperty
   a_data_oe_rfs: assert property (p_data_oe_rfs)
      else $error("data driven without read strobe");

   property p_oe_ready;
      @(posedge clk_i) disable iff (rst_i)
      serial_io_line_oe_o && sel_result |-> !result_ready_n_o;
   endproperty
   a_oe_ready: assert property (p_oe_ready)
      else $error("result data driven while ready is high");

   property p_ready_fall;
      @(posedge clk_i) disable iff (rst_i)
      out_valid && !done_hold && !word_done |=> !result_ready_n_o;
   endproperty
   a_ready_fall: assert property (p_ready_fall)
      else $error("ready pin did not fall for a buffered word");

   property p_ready_rise;
      @(posedge clk_i) disable iff (rst_i)
      word_done && sel_result |=> result_ready_n_o [*2];
   endproperty
   a_ready_rise: assert property (p_ready_rise)
      else $error("ready pin did not rise after a word");

   property p_cal_ready;
      @(posedge clk_i) disable iff (rst_i)
      cal_done_i && state == asp_pkg::ASP_IDLE && !done_hold
         |-> ##2 !result_ready_n_o;
   endproperty
   a_cal_ready: assert property (p_cal_ready)
      else $error("calibration end not flagged on ready pin");

   property p_ctrl_load;
      @(posedge clk_i) disable iff (rst_i)
      !$stable(control_config_word_o) |->
         $past(state) == asp_pkg::ASP_WRITE &&
         $past(bit_cnt) == asp_pkg::LAST_BIT && !$past(sel_result);
   endproperty
   a_ctrl_load: assert property (p_ctrl_load)
      else $error("control word changed outside a full write");

   property p_cnt_cap;
      @(posedge clk_i) disable iff (rst_i)
      state == asp_pkg::ASP_WRITE && bit_cnt == asp_pkg::FULL_WORD
         |=> bit_cnt == asp_pkg::FULL_WORD || state == asp_pkg::ASP_IDLE;
   endproperty
   a_cnt_cap: assert property (p_cnt_cap)
      else $error("bit count moved past a full word");

   property p_result_code;
      @(posedge clk_i) disable iff (rst_i)
      state == asp_pkg::ASP_IDLE && pin_fall[1] && !pin_fall[0] && pin[2]
         |=> shifter[WORD_W-1] == ($past(out_data[WORD_W-1]) ^
             ~control_config_word_o[asp_pkg::UNIPOLAR_BIT]);
   endproperty
   a_result_code: assert property (p_result_code)
      else $error("result coding does not follow range bit");

   property p_ctrl_read;
      @(posedge clk_i) disable iff (rst_i)
      state == asp_pkg::ASP_IDLE && pin_fall[1] && !pin_fall[0] && !pin[2]
         |=> shifter == control_config_word_o;
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control word read not loaded");

   c_write_full: cover property (@(posedge clk_i) disable iff (rst_i)
      state == asp_pkg::ASP_WRITE && bit_cnt == asp_pkg::FULL_WORD);
   c_result_read: cover property (@(posedge clk_i) disable iff (rst_i)
      word_done && sel_result);
   c_cal_done: cover property (@(posedge clk_i) disable iff (rst_i)
      cal_done_i);
   c_self_read: cover property (@(posedge clk_i) disable iff (rst_i)
      word_done && self_mode);

endmodule : asp_serial_port

/* tb/asp_host_model.sv */
// host side of the serial port: frame strobes, select, clock, write data
// assumes the bench resolves the shared clock and data wires from enables
`timescale 1ns/1ns
module asp_host_model (
   // clock and observed pins
   input  wire logic clk_i,
   input  wire logic self_clock_i,
   input  wire logic sclk_pin_i,
   input  wire logic data_pin_i,
   input  wire logic sclk_oe_i,
   input  wire logic data_oe_i,
   input  wire logic result_ready_n_i,
   // driven pins
   output logic      write_frame_strobe_n_o,
   output logic      read_frame_strobe_n_o,
   output logic      register_select_o,
   output logic      host_sclk_o,
   output logic      host_data_o,
   output logic      host_data_en_o
);
   initial begin
      write_frame_strobe_n_o = 1'b1;
      read_frame_strobe_n_o  = 1'b1;
      register_select_o      = 1'b0;
      host_sclk_o            = 1'b1;
      host_data_o            = 1'b0;
      host_data_en_o         = 1'b0;
   end

   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : tick

   // one frame; nb clock rises, read bits gathered into rd
   task frame(input logic wr, input logic sel, input logic [23:0] wd,
              input int nb, output logic [23:0] rd, output logic pre_oe,
              output logic any_oe, output logic rdy_end);
      int   n;
      int   t;
      logic prev;
      logic pd;
      logic po;
      rd = 24'h00_0000;
      any_oe = 1'b0;
      n = 0;
      register_select_o = sel;
      tick(2);
      pre_oe = sclk_oe_i | data_oe_i;
      if (wr) begin
         write_frame_strobe_n_o = 1'b0;
      end else begin
         read_frame_strobe_n_o = 1'b0;
      end
      tick(1);
      // first bit only after the strobe fell
      host_data_en_o = wr;
      host_data_o = wd[23];
      tick(6);
      if (!self_clock_i) begin
         for (n = 0; n < nb; n++) begin
            host_sclk_o = 1'b0;
            host_data_o = (n < 24) ? wd[23-n] : n[0];
            tick(4);
            host_sclk_o = 1'b1;
            tick(3);
            // late in the high phase: device data moves ~4 clk after a fall
            rd = {rd[22:0], data_pin_i};
            any_oe |= data_oe_i;
            tick(1);
         end
      end else begin
         for (t = 0; t < 600 && n < nb; t++) begin
            prev = sclk_pin_i;
            pd = data_pin_i;
            po = data_oe_i;
            tick(1);
            // a rise takes the data as it stood just before the edge
            if (!prev && sclk_pin_i) begin
               n++;
               rd = {rd[22:0], pd};
               any_oe |= po;
               // device data path lags its own clock, so move after a rise
               if (n < 24) begin
                  host_data_o = wd[23-n];
               end
            end
         end
      end
      tick(6);
      rdy_end = result_ready_n_i;
      write_frame_strobe_n_o = 1'b1;
      read_frame_strobe_n_o = 1'b1;
      host_data_en_o = 1'b0;
      tick(8);
   endtask : frame
endmodule : asp_host_model

/* tb/tb.sv */
// self-checking bench of the framed serial port and its result buffer
// assumes the host model in its own file and the design package
`timescale 1ns/1ns
module tb;
   localparam logic [23:0] ZERO = 24'h00_0000;
   localparam logic [23:0] ONE  = 24'h00_0001;
   logic clk_i, rst_i, write_frame_strobe_n_i, read_frame_strobe_n_i;
   logic register_select_i, self_clock_i, sclk_i, sclk_o, sclk_oe_o;
   logic serial_io_line_i, serial_io_line_o, serial_io_line_oe_o;
   logic result_ready_n_o, sample_valid_i, sample_ready_o, cal_done_i;
   logic [23:0] sample_i, control_config_word_o, rd, w, s;
   logic        pre, any, rdy, hsclk, hd, hden, uni;
   logic        noise = 1'b0;
   logic [23:0] q[$];
   int          miscompares, n_checks;

   // undriven wires show a moving pattern, never a held last value
   assign sclk_i = sclk_oe_o ? sclk_o : (self_clock_i ? noise : hsclk);
   assign serial_io_line_i = serial_io_line_oe_o ? serial_io_line_o
                             : (hden ? hd : noise);

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) noise <= ~noise;

   asp_serial_port dut_u (.clk_i, .rst_i, .write_frame_strobe_n_i,
      .read_frame_strobe_n_i, .register_select_i, .self_clock_i, .sclk_i,
      .sclk_o, .sclk_oe_o, .serial_io_line_i, .serial_io_line_o,
      .serial_io_line_oe_o, .result_ready_n_o, .sample_i, .sample_valid_i,
      .sample_ready_o, .cal_done_i, .control_config_word_o);

   asp_host_model host_u (.clk_i, .self_clock_i, .sclk_pin_i(sclk_i),
      .data_pin_i(serial_io_line_i), .sclk_oe_i(sclk_oe_o),
      .data_oe_i(serial_io_line_oe_o), .result_ready_n_i(result_ready_n_o),
      .write_frame_strobe_n_o(write_frame_strobe_n_i),
      .read_frame_strobe_n_o(read_frame_strobe_n_i),
      .register_select_o(register_select_i), .host_sclk_o(hsclk),
      .host_data_o(hd), .host_data_en_o(hden));

   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : tick

   task check(input string nm, input logic [23:0] seen,
              input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   function logic [23:0] code(input logic [23:0] v, input logic u);
      return u ? v : v ^ 24'h80_0000;
   endfunction : code

   // random control word kept in normal mode
   function logic [23:0] cw(input logic u);
      logic [23:0] r;
      r = 24'($urandom);
      r[asp_pkg::MODE_HI:asp_pkg::MODE_LO] = asp_pkg::MODE_NORMAL;
      r[asp_pkg::UNIPOLAR_BIT] = u;
      return r;
   endfunction : cw

   task push(input logic [23:0] v);
      int k;
      sample_i = v;
      sample_valid_i = 1'b1;
      for (k = 0; k < 50 && sample_ready_o !== 1'b1; k++) tick(1);
      tick(1);
      sample_valid_i = 1'b0;
      tick(1);
   endtask : push

   task wr(input logic [23:0] v, input int nb, input logic sel);
      host_u.frame(1'b1, sel, v, nb, rd, pre, any, rdy);
   endtask : wr

   task rdf(input logic sel);
      host_u.frame(1'b0, sel, ZERO, 24, rd, pre, any, rdy);
   endtask : rdf

   task conclude;
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (40000) @(posedge clk_i);
      miscompares++;
      conclude();
   end

   initial begin
      rst_i = 1'b1;
      sample_i = ZERO;
      sample_valid_i = 1'b0;
      cal_done_i = 1'b0;
      self_clock_i = 1'b0;
      miscompares = 0;
      n_checks = 0;
      uni = 1'b0;
      void'($urandom(32'h1eb6894c));
      repeat (12) @(posedge clk_i);
      #2;
      rst_i = 1'b0;
      tick(6);
      check("ctrl reset", control_config_word_o, asp_pkg::CTRL_RESET);
      check("ready reset", 24'(result_ready_n_o), ONE);
      check("oe idle", 24'({sclk_oe_o, serial_io_line_oe_o}), ZERO);
      // external clock first, then the device drives the clock
      for (int m = 0; m < 2; m++) begin
         self_clock_i = m[0];
         tick(8);
         uni = m[0];
         w = cw(uni);
         wr(w, 24, 1'b0);
         check("ctrl write", control_config_word_o, w);
         check("clock early", 24'(pre), ZERO);
         rdf(1'b0);
         check("ctrl read", rd, w);
         check("drive early", 24'(pre), ZERO);
      end
      self_clock_i = 1'b0;
      tick(8);
      wr(~w, 23, 1'b0);
      check("short write", control_config_word_o, w);
      wr(~w, 24, 1'b1);
      check("select high write", control_config_word_o, w);
      w = cw(uni);
      wr(w, 30, 1'b0);
      check("long write", control_config_word_o, w);
      rdf(1'b1);
      check("empty read driven", 24'(any), ZERO);
      // both codings with the extreme words, then random ones
      for (int m = 0; m < 6; m++) begin
         uni = m[0];
         wr(cw(uni), 24, 1'b0);
         s = (m < 2) ? 24'h80_0000 : (m < 4) ? 24'h7F_FFFF : 24'($urandom);
         push(s);
         tick(4);
         check("ready on word", 24'(result_ready_n_o), ZERO);
         rdf(1'b1);
         check("result", rd, code(s, uni));
         check("ready after word", 24'(rdy), ONE);
      end
      // fill the buffer while the host stalls, then drain it
      for (int m = 0; m < 8; m++) begin
         s = 24'($urandom);
         q.push_back(s);
         push(s);
      end
      tick(2);
      check("buffer full", 24'(sample_ready_o), ZERO);
      while (q.size() > 0) begin
         rdf(1'b1);
         check("drain", rd, code(q.pop_front(), uni));
      end
      check("ready empty", 24'(result_ready_n_o), ONE);
      cal_done_i = 1'b1;
      tick(1);
      cal_done_i = 1'b0;
      tick(3);
      check("ready on cal", 24'(result_ready_n_o), ZERO);
      rdf(1'b1);
      check("cal cleared", 24'(result_ready_n_o), ONE);
      conclude();
   end
endmodule : tb
